// ---- hdl/qsc_pkg.sv ----
/*
 * Shared constants and types for the switch trigger and fault core.
 * Assumes a 20 MHz core clock and comparator flags already synchronous.
 */
package qsc_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_NS = 50;
   localparam int NS_PER_MS = 1000000;
   localparam int T_START_NS = 127500;
   localparam int T_SMIN_NS = 8500;
   localparam int T_AUTO_NS = 5000;
   localparam int T_ON_MAX_NS = 20000;
   localparam int T_DIM_MS = 15;
   localparam int T_MASK_MS = 30;
   localparam int T_PERSIST_MS = 70;
   localparam int T_RESTART_MS = 1;
   localparam int START_CYC = T_START_NS / CLK_NS;
   localparam int SMIN_CYC = (T_SMIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int AUTO_CYC = (T_AUTO_NS + CLK_NS - 1) / CLK_NS;
   localparam int ON_MAX_CYC = T_ON_MAX_NS / CLK_NS;
   localparam int DIM_CYC = T_DIM_MS * NS_PER_MS / CLK_NS;
   localparam int MASK_CYC = T_MASK_MS * NS_PER_MS / CLK_NS;
   localparam int PERSIST_CYC = T_PERSIST_MS * NS_PER_MS / CLK_NS;
   localparam int RESTART_CYC = T_RESTART_MS * NS_PER_MS / CLK_NS;
   // Switching cycles that make "a few"
   localparam int FEW_CYC = 3;
   localparam int PER_W = 12;
   localparam int LT_W = 21;
   localparam int ON_W = 16;
   localparam int FEW_W = 2;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {QSC_IDLE, QSC_WAIT, QSC_ON} qsc_state_t;

   typedef struct packed {
      logic valley;
      logic demag_ovp;
      logic demag_low;
      logic cs_over_limit;
      logic cs_over_short;
      logic cs_over_ext_hot;
      logic vdd_above_on;
      logic vdd_below_off;
      logic vdd_ovp;
      logic line_ovp;
      logic line_brown_out;
      logic line_brown_in;
      logic comp_overload;
      logic die_hot;
      logic die_cool;
      logic dim_below_dis;
   } qsc_sense_t;

   typedef struct packed {
      logic [1:0] cv_ref;
      logic [2:0] qr_delay;
   } qsc_setting_t;

   // Fault and long timer indices
   localparam int F_OVP = 0;
   localparam int F_SHORT = 1;
   localparam int F_DIODE = 2;
   localparam int F_VDD = 3;
   localparam int F_LINE_OV = 4;
   localparam int F_BROWN = 5;
   localparam int F_OLP = 6;
   localparam int F_DIE = 7;
   localparam int F_EXT = 8;
   localparam int NFAULT = 9;
   localparam int LT_DIM = 0;
   localparam int LT_MASK = 1;
   localparam int LT_BROWN = 2;
   localparam int LT_OLP = 3;
   localparam int LT_EXT = 4;
   localparam int NLT = 5;

   // ==========================================================
   // Register map
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_ON_TIME = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_SETTING = 8'h0c;
   localparam int CTRL_RUN_BIT = 0;
   localparam logic CTRL_RUN_RST = 1'h1;
   localparam logic [ON_W-1:0] ON_TIME_RST = 16'h00c8;
   localparam int ST_FV_BIT = 9;
   localparam int ST_EN_BIT = 10;
   localparam int ST_DRV_BIT = 11;
   localparam int ST_MASK_BIT = 12;
   localparam int SET_QR_LSB = 2;
   localparam int SET_FAC_LSB = 8;
   localparam logic [7:0] DIM_LOW_CODE = 8'h1c;
   localparam logic [7:0] DIM_HIGH_CODE = 8'hd9;
endpackage

// ---- hdl/qsc_switch_ctrl.sv ----
/*
 * Switch trigger and fault supervisor of a quasi-resonant LED driver,
 * with an APB register slave. Assumes comparator flags synchronous to
 * CORE_CLK and an external gate driver on SWITCH_DRIVE.
 */
// The address map and the APB slave port are this design's own decisions.
// Functional notes
// - Starter fires next pulse 127.5 us after interval start without valley.
// - 8.5 us minimum-period window from drive rise blocks valley triggers.
// - First valley after the window starts the next pulse.
// - Valley seen inside window, none after: fire 5 us after window end.
// - Dim input below disable level for 15 ms selects fixed voltage mode.
// - Demag overvoltage forces drive low; auto restart, re-trips if present.
// - Demag low with peak limit few cycles shuts down; restarts on recovery.
// - Short-circuit detection masked first 30 ms after supply turn-on.
// - Current above diode-short level stops drive within few cycles.
// - Enable above turn-on level, disable below turn-off level.
// - Supply overvoltage stops drive; resumes when supply normal.
// - Line overvoltage current for few cycles shuts drive off.
// - Brown-out for 70 ms shuts down until brown-in.
// - Loop error at overload level for 70 ms turns switch off.
// - Die above hot level shuts down until below cool level.
// - Current sense above ext hot level in off time 70 ms shuts down.
// - Regulation factor linear in averaged dim level between thresholds.
// - After startup latch voltage reference and valley delay settings.
`timescale 1ns/100ps
module qsc_switch_ctrl import qsc_pkg::*; #(
   parameter int unsigned DIM_LIM = DIM_CYC,
   parameter int unsigned MASK_LIM = MASK_CYC,
   parameter int unsigned PERSIST_LIM = PERSIST_CYC,
   parameter int unsigned RESTART_LIM = RESTART_CYC
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire qsc_sense_t SENSE,
   input wire logic [7:0] DIM_LEVEL,
   input wire qsc_setting_t SETTING_IN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic SWITCH_DRIVE,
   output logic FIXED_VOLTAGE_MODE,
   output logic DEVICE_ENABLED,
   output logic [7:0] CURRENT_REG_FACTOR,
   output qsc_setting_t SETTING_OUT
);
   // ==========================================================
   // Declarations
   localparam logic [PER_W-1:0] P_SMIN = PER_W'(SMIN_CYC);
   localparam logic [PER_W-1:0] P_AUTO = PER_W'(SMIN_CYC + AUTO_CYC - 1);
   localparam logic [PER_W-1:0] P_START = PER_W'(START_CYC - 1);
   localparam logic [ON_W-1:0] P_ON_MAX = ON_W'(ON_MAX_CYC);
   localparam logic [LT_W-1:0] P_RESTART = LT_W'(RESTART_LIM);
   localparam int unsigned LT_LIM [NLT] =
      '{DIM_LIM, MASK_LIM, PERSIST_LIM, PERSIST_LIM, PERSIST_LIM};

   qsc_state_t state_reg;
   logic [PER_W-1:0] per_cnt_reg;
   logic [ON_W-1:0] on_cnt_reg;
   logic seen_valley_reg;
   logic en_reg;
   logic en_q_reg;
   logic run_reg;
   logic [ON_W-1:0] on_time_reg;
   logic [NFAULT-1:0] fault_reg;
   logic [LT_W-1:0] lt_cnt_reg [NLT];
   logic [NLT-1:0] lt_cond;
   logic [NLT-1:0] lt_done;
   logic [FEW_W-1:0] few_cnt_reg [2];
   logic [1:0] few_cond;
   logic [1:0] few_done;
   logic [LT_W-1:0] restart_cnt_reg;
   logic restart_done;
   logic [NFAULT-1:0] fset;
   logic [NFAULT-1:0] frel;
   logic run_ok;
   logic fire;
   logic start_pulse;
   logic ready_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rd_next;
   logic wr_en;
   logic [ON_W-1:0] on_time_next;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = hit(a, ADDR_CTRL) | hit(a, ADDR_ON_TIME) |
               hit(a, ADDR_STATUS) | hit(a, ADDR_SETTING);
   endfunction

   // ==========================================================
   // APB slave
   // Ready is held off while CE is low so no write is lost
   assign PREADY = ready_reg & PENABLE & CE;
   assign PSLVERR = PREADY & ~mapped(PADDR);
   assign PRDATA = prdata_reg;
   assign wr_en = PSEL & PENABLE & PWRITE & PREADY;

   always_comb begin
      rd_next = 32'h0;
      if (hit(PADDR, ADDR_CTRL)) begin
         rd_next[CTRL_RUN_BIT] = run_reg;
      end else if (hit(PADDR, ADDR_ON_TIME)) begin
         rd_next[ON_W-1:0] = on_time_reg;
      end else if (hit(PADDR, ADDR_STATUS)) begin
         rd_next[NFAULT-1:0] = fault_reg;
         rd_next[ST_FV_BIT] = FIXED_VOLTAGE_MODE;
         rd_next[ST_EN_BIT] = en_reg;
         rd_next[ST_DRV_BIT] = SWITCH_DRIVE;
         rd_next[ST_MASK_BIT] = ~lt_done[LT_MASK];
      end else if (hit(PADDR, ADDR_SETTING)) begin
         rd_next[1:0] = SETTING_OUT.cv_ref;
         rd_next[SET_QR_LSB +: 3] = SETTING_OUT.qr_delay;
         rd_next[SET_FAC_LSB +: 8] = CURRENT_REG_FACTOR;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         ready_reg <= 1'b0;
         prdata_reg <= 32'h0;
      end else if (CE) begin
         if (PSEL && PENABLE && ready_reg) begin
            ready_reg <= 1'b0;
         end else if (PSEL) begin
            ready_reg <= 1'b1;
            prdata_reg <= rd_next;
         end
      end
   end

   // Zero on-time would stall the pulse, so it is clamped
   always_comb begin
      on_time_next = PWDATA[ON_W-1:0];
      if (on_time_next == '0) begin
         on_time_next = ON_W'(1);
      end else if (on_time_next > P_ON_MAX) begin
         on_time_next = P_ON_MAX;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         run_reg <= CTRL_RUN_RST;
         on_time_reg <= ON_TIME_RST;
      end else if (CE && wr_en) begin
         if (hit(PADDR, ADDR_CTRL)) begin
            run_reg <= PWDATA[CTRL_RUN_BIT];
         end
         if (hit(PADDR, ADDR_ON_TIME)) begin
            on_time_reg <= on_time_next;
         end
      end
   end

   // ==========================================================
   // Supply lockout and startup settings
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         en_reg <= 1'b0;
         en_q_reg <= 1'b0;
         SETTING_OUT <= '0;
      end else if (CE) begin
         if (SENSE.vdd_above_on) begin
            en_reg <= 1'b1;
         end else if (SENSE.vdd_below_off) begin
            en_reg <= 1'b0;
         end
         en_q_reg <= en_reg;
         if (en_reg && !en_q_reg) begin
            SETTING_OUT <= SETTING_IN;
         end
      end
   end
   assign DEVICE_ENABLED = en_reg;

   // ==========================================================
   // Persistence timers
   assign lt_cond[LT_DIM] = SENSE.dim_below_dis;
   assign lt_cond[LT_MASK] = en_reg;
   assign lt_cond[LT_BROWN] = en_reg & SENSE.line_brown_out;
   assign lt_cond[LT_OLP] = en_reg & SENSE.comp_overload;
   // External hot is only meaningful while the switch is off
   assign lt_cond[LT_EXT] = en_reg & SENSE.cs_over_ext_hot & ~SWITCH_DRIVE;

   generate
      for (genvar i = 0; i < NLT; i++) begin : g_lt
         assign lt_done[i] = (lt_cnt_reg[i] == LT_W'(LT_LIM[i]));
         always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
               lt_cnt_reg[i] <= '0;
            end else if (CE) begin
               if (!lt_cond[i]) begin
                  lt_cnt_reg[i] <= '0;
               end else if (!lt_done[i]) begin
                  lt_cnt_reg[i] <= lt_cnt_reg[i] + LT_W'(1);
               end
            end
         end
      end
   endgenerate

   // Few-switching-cycle qualifiers, counted on each pulse start
   assign few_cond[0] = SENSE.demag_low & SENSE.cs_over_limit;
   assign few_cond[1] = SENSE.line_ovp;

   generate
      for (genvar j = 0; j < 2; j++) begin : g_few
         assign few_done[j] = (few_cnt_reg[j] == FEW_W'(FEW_CYC));
         always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
               few_cnt_reg[j] <= '0;
            end else if (CE) begin
               if (!few_cond[j] || !en_reg) begin
                  few_cnt_reg[j] <= '0;
               end else if (start_pulse && !few_done[j]) begin
                  few_cnt_reg[j] <= few_cnt_reg[j] + FEW_W'(1);
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // Fault supervisor
   // Auto-restart faults hold off for a restart time before release
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         restart_cnt_reg <= '0;
      end else if (CE) begin
         if (!(fault_reg[F_OVP] | fault_reg[F_SHORT] | fault_reg[F_OLP])) begin
            restart_cnt_reg <= '0;
         end else if (!restart_done) begin
            restart_cnt_reg <= restart_cnt_reg + LT_W'(1);
         end
      end
   end
   assign restart_done = (restart_cnt_reg == P_RESTART);

   always_comb begin
      fset[F_OVP] = SENSE.demag_ovp;
      frel[F_OVP] = restart_done;
      fset[F_SHORT] = few_done[0] & lt_done[LT_MASK];
      frel[F_SHORT] = restart_done & ~SENSE.demag_low;
      fset[F_DIODE] = SENSE.cs_over_short;
      frel[F_DIODE] = ~SENSE.cs_over_short;
      fset[F_VDD] = SENSE.vdd_ovp;
      frel[F_VDD] = ~SENSE.vdd_ovp;
      fset[F_LINE_OV] = few_done[1];
      frel[F_LINE_OV] = ~SENSE.line_ovp;
      fset[F_BROWN] = lt_done[LT_BROWN];
      frel[F_BROWN] = SENSE.line_brown_in;
      fset[F_OLP] = lt_done[LT_OLP];
      frel[F_OLP] = restart_done & ~SENSE.comp_overload;
      fset[F_DIE] = SENSE.die_hot;
      frel[F_DIE] = SENSE.die_cool;
      fset[F_EXT] = lt_done[LT_EXT];
      frel[F_EXT] = ~SENSE.cs_over_ext_hot;
   end

   // Lockout clears every protection; set wins over release
   generate
      for (genvar k = 0; k < NFAULT; k++) begin : g_flt
         always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
               fault_reg[k] <= 1'b0;
            end else if (CE) begin
               if (!en_reg) begin
                  fault_reg[k] <= 1'b0;
               end else if (fset[k]) begin
                  fault_reg[k] <= 1'b1;
               end else if (frel[k]) begin
                  fault_reg[k] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // Dimming and mode
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         FIXED_VOLTAGE_MODE <= 1'b0;
         CURRENT_REG_FACTOR <= 8'h00;
      end else if (CE) begin
         FIXED_VOLTAGE_MODE <= lt_done[LT_DIM];
         if (DIM_LEVEL <= DIM_LOW_CODE) begin
            CURRENT_REG_FACTOR <= 8'h00;
         end else if (DIM_LEVEL >= DIM_HIGH_CODE) begin
            CURRENT_REG_FACTOR <= DIM_HIGH_CODE - DIM_LOW_CODE;
         end else begin
            CURRENT_REG_FACTOR <= DIM_LEVEL - DIM_LOW_CODE;
         end
      end
   end

   // ==========================================================
   // Switch trigger
   assign run_ok = en_reg & run_reg & ~|fault_reg;
   assign fire = (per_cnt_reg >= P_SMIN && SENSE.valley) ||
                 (seen_valley_reg && per_cnt_reg >= P_AUTO) ||
                 (per_cnt_reg >= P_START);
   assign start_pulse = (state_reg == QSC_WAIT) & run_ok & fire;

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         state_reg <= QSC_IDLE;
         SWITCH_DRIVE <= 1'b0;
         per_cnt_reg <= '0;
         on_cnt_reg <= '0;
         seen_valley_reg <= 1'b0;
      end else if (CE) begin
         if (per_cnt_reg != '1) begin
            per_cnt_reg <= per_cnt_reg + PER_W'(1);
         end
         case (state_reg)
            QSC_IDLE: begin
               SWITCH_DRIVE <= 1'b0;
               per_cnt_reg <= '0;
               seen_valley_reg <= 1'b0;
               if (run_ok) begin
                  state_reg <= QSC_WAIT;
               end
            end
            QSC_WAIT: begin
               if (!run_ok) begin
                  state_reg <= QSC_IDLE;
               end else if (fire) begin
                  state_reg <= QSC_ON;
                  SWITCH_DRIVE <= 1'b1;
                  per_cnt_reg <= '0;
                  on_cnt_reg <= '0;
                  seen_valley_reg <= 1'b0;
               end else if (SENSE.valley && per_cnt_reg < P_SMIN) begin
                  seen_valley_reg <= 1'b1;
               end
            end
            QSC_ON: begin
               on_cnt_reg <= on_cnt_reg + ON_W'(1);
               if (!run_ok) begin
                  state_reg <= QSC_IDLE;
                  SWITCH_DRIVE <= 1'b0;
               end else if (on_cnt_reg >= on_time_reg - ON_W'(1) ||
                            SENSE.cs_over_limit) begin
                  state_reg <= QSC_WAIT;
                  SWITCH_DRIVE <= 1'b0;
               end
            end
            default: begin
               state_reg <= QSC_IDLE;
               SWITCH_DRIVE <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   a_starter_fire: assert property (
      CE && state_reg == QSC_WAIT && run_ok && per_cnt_reg == P_START
      |=> SWITCH_DRIVE) else $error("starter did not fire");
   a_min_period: assert property (
      $rose(SWITCH_DRIVE) |-> $past(per_cnt_reg) >= P_SMIN
      || $past(per_cnt_reg) == '0)
      else $error("pulse inside minimum period");
   a_valley_fire: assert property (
      CE && state_reg == QSC_WAIT && run_ok && SENSE.valley
      && per_cnt_reg >= P_SMIN |=> SWITCH_DRIVE)
      else $error("valley after window ignored");
   a_auto_fire: assert property (
      CE && state_reg == QSC_WAIT && run_ok && seen_valley_reg
      && per_cnt_reg == P_AUTO |=> SWITCH_DRIVE)
      else $error("auto trigger missed");
   a_short_mask: assert property (
      !lt_done[LT_MASK] && !fault_reg[F_SHORT] |=> !fault_reg[F_SHORT])
      else $error("short fault during mask");
   a_diode_trip: assert property (
      CE && en_reg && SENSE.cs_over_short ##1 CE |=> !SWITCH_DRIVE)
      else $error("diode short did not stop drive");
   a_uvlo_on: assert property (
      CE && SENSE.vdd_above_on |=> DEVICE_ENABLED)
      else $error("enable not taken");
   a_vdd_ovp: assert property (
      CE && en_reg && SENSE.vdd_ovp |=> fault_reg[F_VDD])
      else $error("supply overvoltage missed");
   a_timer_clear: assert property (
      CE && !SENSE.comp_overload |=> lt_cnt_reg[LT_OLP] == '0)
      else $error("persistence timer not cleared");
   a_fault_drive: assert property (
      CE && |fault_reg |=> !SWITCH_DRIVE)
      else $error("drive high under fault");

   c_valley_start: cover property (
      state_reg == QSC_WAIT && SENSE.valley && start_pulse);
   c_auto_start: cover property (
      start_pulse && seen_valley_reg && !SENSE.valley);
   c_fault_stop: cover property (SWITCH_DRIVE ##1 |fault_reg);
endmodule // qsc_switch_ctrl

// ---- testbench/qsc_ring_model.sv ----
/*
 * Far-side model: switch node ringing that shows one valley per period.
 * Assumes the core drive enable and a valley delay set by the bench.
 */
`timescale 1ns/100ps
module qsc_ring_model (
   input wire logic clk,
   input wire logic drive,
   input wire logic [11:0] delay,
   output logic valley
);
   logic drive_q = 1'b0;
   logic [11:0] cnt = '0;

   // ==========================================================
   // Period count, aligned with the core's count from drive rise
   always @(posedge clk) begin
      drive_q <= drive;
      cnt <= (drive && !drive_q) ? 12'h001 : cnt + 12'h001;
   end

   // Zero delay: the node never rings down to a valley
   assign valley = (delay != '0) && (cnt == delay) && !drive;
endmodule // qsc_ring_model

// ---- testbench/test_qsc_switch_ctrl.sv ----
/*
 * Self-checking bench for the switch trigger and fault core.
 * Assumes the ring model beside it and shortened long timers.
 */
`timescale 1ns/100ps
module test_qsc_switch_ctrl import qsc_pkg::*; ();
   localparam int P_DIM = 50;
   localparam int P_PERS = 60;
   localparam int P_RST = 30;
   logic CORE_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic CE = 1'b1;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [ADDR_W-1:0] PADDR = '0;
   logic [31:0] PWDATA = '0;
   logic [31:0] PRDATA, rd;
   logic PREADY, PSLVERR, SWITCH_DRIVE, FIXED_VOLTAGE_MODE, DEVICE_ENABLED;
   logic [7:0] DIM_LEVEL = '0;
   logic [7:0] CURRENT_REG_FACTOR, lv;
   qsc_sense_t sense = '0;
   qsc_sense_t sense_w;
   qsc_setting_t SETTING_IN = '0;
   qsc_setting_t SETTING_OUT;
   logic [11:0] vdelay = '0;
   logic valley, err;
   logic drv_q = 1'b0;
   int n_fail = 0;
   int comparisons = 0;
   int cyc = 0;
   int c;
   int dl[5] = '{0, 200, 100, 169, 170};
   // Sense bits that raise each fault; the last is demag low with peak limit
   logic [15:0] fm[9] = '{16'h4000, 16'h0800, 16'h0080, 16'h0004, 16'h0020,
      16'h0008, 16'h0040, 16'h0400, 16'h3000};
   int fi[9] = '{F_OVP, F_DIODE, F_VDD, F_DIE, F_BROWN, F_OLP, F_LINE_OV,
      F_EXT, F_SHORT};

   always #25 CORE_CLK = ~CORE_CLK;
   always_comb begin
      sense_w = sense;
      sense_w.valley = valley;
   end

   qsc_switch_ctrl #(.DIM_LIM(P_DIM), .MASK_LIM(40), .PERSIST_LIM(P_PERS),
      .RESTART_LIM(P_RST)) DUT (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
      .CE(CE), .SENSE(sense_w), .DIM_LEVEL(DIM_LEVEL),
      .SETTING_IN(SETTING_IN), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .SWITCH_DRIVE(SWITCH_DRIVE),
      .FIXED_VOLTAGE_MODE(FIXED_VOLTAGE_MODE),
      .DEVICE_ENABLED(DEVICE_ENABLED),
      .CURRENT_REG_FACTOR(CURRENT_REG_FACTOR), .SETTING_OUT(SETTING_OUT));

   qsc_ring_model ring (.clk(CORE_CLK), .drive(SWITCH_DRIVE),
      .delay(vdelay), .valley(valley));

   // ==========================================================
   // Watchdog and helpers
   always @(posedge CORE_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         end_of_test();
      end
   end
   always @(negedge CORE_CLK) drv_q <= SWITCH_DRIVE;

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // Entered just after a rising edge; one idle edge follows the access
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      do @(posedge CORE_CLK); while (PREADY !== 1'b1);
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CORE_CLK);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge CORE_CLK);
      @(negedge CORE_CLK);
   endtask

   task automatic next_rise(output int n);
      n = 0;
      do begin
         @(negedge CORE_CLK);
         n++;
      end while (!(SWITCH_DRIVE === 1'b1 && drv_q === 1'b0) && n < 6000);
   endtask

   task automatic hi_count(input int n, output int h);
      h = 0;
      repeat (n) begin
         @(negedge CORE_CLK);
         if (SWITCH_DRIVE !== 1'b0) h++;
      end
   endtask

   function automatic int exp_period(input int d);
      if (d == 0) return START_CYC;
      if (d >= SMIN_CYC) return d + 1;
      return SMIN_CYC + AUTO_CYC;
   endfunction

   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(32'he43f9ad2));
      repeat (8) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      @(posedge CORE_CLK);
      apb(1'b0, ADDR_CTRL, '0, rd, err);
      chk(rd, {31'h0, CTRL_RUN_RST});
      apb(1'b0, ADDR_ON_TIME, '0, rd, err);
      chk(rd, {16'h0, ON_TIME_RST});
      apb(1'b0, 8'h10, '0, rd, err);
      chk({rd[30:0], err}, 32'h1);
      apb(1'b1, ADDR_ON_TIME, '0, rd, err);
      apb(1'b0, ADDR_ON_TIME, '0, rd, err);
      chk(rd, 32'h1);
      apb(1'b1, ADDR_ON_TIME, 32'hffff, rd, err);
      apb(1'b0, ADDR_ON_TIME, '0, rd, err);
      chk(rd, 32'h190);
      apb(1'b1, ADDR_ON_TIME, 32'h14, rd, err);
      $display("test registers done");
      SETTING_IN <= 5'($urandom);
      sense.vdd_above_on <= 1'b1;
      settle(4);
      chk(DEVICE_ENABLED, 1'b1);
      chk(SETTING_OUT, SETTING_IN);
      foreach (dl[i]) begin
         @(posedge CORE_CLK);
         vdelay <= 12'(dl[i]);
         next_rise(c);
         next_rise(c);
         chk(c, exp_period(dl[i]));
      end
      // One valley period at delay 170 holds exactly one programmed pulse
      hi_count(171, c);
      chk(c, 32'h14);
      apb(1'b1, ADDR_CTRL, '0, rd, err);
      hi_count(300, c);
      chk(c, 0);
      apb(1'b1, ADDR_CTRL, 32'h1, rd, err);
      $display("test trigger done");
      for (int i = 0; i < 9; i++) begin
         // Pulse-counted and off-time faults need switching running
         if (i > 5) next_rise(c);
         @(posedge CORE_CLK);
         sense <= sense | fm[i];
         if (i > 3) begin
            repeat (P_PERS - 10) @(posedge CORE_CLK);
            apb(1'b0, ADDR_STATUS, '0, rd, err);
            chk(rd[8:0], 0);
         end
         // Long enough for three pulses at the valley period
         repeat (600) @(posedge CORE_CLK);
         apb(1'b0, ADDR_STATUS, '0, rd, err);
         chk(rd[8:0], 1 << fi[i]);
         hi_count(300, c);
         chk(c, 0);
         @(posedge CORE_CLK);
         sense <= sense & ~fm[i];
         repeat (P_RST + 20) @(posedge CORE_CLK);
         apb(1'b0, ADDR_STATUS, '0, rd, err);
         chk(rd[8:0], (i == 3 || i == 4) ? 1 << fi[i] : 0);
         sense.die_cool <= 1'b1;
         sense.line_brown_in <= 1'b1;
         repeat (5) @(posedge CORE_CLK);
         apb(1'b0, ADDR_STATUS, '0, rd, err);
         chk(rd[8:0], 0);
         sense.die_cool <= 1'b0;
         sense.line_brown_in <= 1'b0;
      end
      $display("test faults done");
      for (int i = 0; i < 8; i++) begin
         @(posedge CORE_CLK);
         lv = i == 0 ? DIM_LOW_CODE : i == 1 ? DIM_HIGH_CODE : 8'($urandom);
         // Averaged level of a dimming pulse train: both band ends, then random codes in or out of band
         DIM_LEVEL <= lv;
         settle(3);
         chk(CURRENT_REG_FACTOR, lv < DIM_LOW_CODE ? 8'h0 :
            lv > DIM_HIGH_CODE ? DIM_HIGH_CODE - DIM_LOW_CODE :
            lv - DIM_LOW_CODE);
      end
      @(posedge CORE_CLK);
      sense.dim_below_dis <= 1'b1;
      settle(P_DIM - 5);
      chk(FIXED_VOLTAGE_MODE, 1'b0);
      settle(10);
      chk(FIXED_VOLTAGE_MODE, 1'b1);
      $display("test dimming done");
      @(posedge CORE_CLK);
      sense.vdd_above_on <= 1'b0;
      settle(5);
      chk(DEVICE_ENABLED, 1'b1);
      @(posedge CORE_CLK);
      CE <= 1'b0;
      sense.vdd_below_off <= 1'b1;
      settle(3);
      chk(DEVICE_ENABLED, 1'b1);
      @(posedge CORE_CLK);
      CE <= 1'b1;
      settle(3);
      chk({DEVICE_ENABLED, SWITCH_DRIVE}, 2'b00);
      $display("test lockout done");
      end_of_test();
   end
endmodule // test_qsc_switch_ctrl
